// ### tb/gsi_top_sva.sv
// Checker of bus timing, control outputs and interrupt pins.
`timescale 1ns/1ns
`default_nettype none
module gsi_top_sva (
  // Clock and reset.
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Bus.
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  // Control and interrupt outputs.
  input wire logic [3:0] O_PORT_UPDATE_MODE,
  input wire logic O_GLOBAL_UPDATE_REQUEST,
  input wire logic O_REF8K_INPUT_SELECT,
  input wire logic O_IRQ,
  input wire logic O_INT_N
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  logic req;
  logic ctl_hit;
  logic [5:0] ctrl;
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign ctl_hit = I_AVS_ADDRESS[7:2] == gsi_pkg::ADDR_UPDATE_CONTROL[7:2];
  assign ctrl = {O_REF8K_INPUT_SELECT, O_GLOBAL_UPDATE_REQUEST,
    O_PORT_UPDATE_MODE};
  sequence s_start;
    $rose(req);
  endsequence
  sequence s_answer;
    O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
  endsequence
  sequence s_quiet;
    !O_IRQ ##1 !O_IRQ;
  endsequence
  chk_wait_one: assert property (s_start |-> s_answer)
    else $error("bus answer not after one wait state");
  chk_wait_idle: assert property (!req |-> !O_AVS_WAITREQUEST)
    else $error("waitrequest high without a request");
  chk_wait_again: assert property (req && !O_AVS_WAITREQUEST
    |=> O_AVS_WAITREQUEST == req) else $error("answer held too long");
  chk_ctrl_write: assert property ($changed(ctrl) |->
    $past(I_AVS_WRITE && !O_AVS_WAITREQUEST && ctl_hit))
    else $error("control output changed without a write");
  chk_ctrl_read: assert property (I_AVS_READ && O_AVS_WAITREQUEST &&
    ctl_hit |=> O_AVS_READDATA[15:0] == {10'h000, $past(ctrl)})
    else $error("control read-back differs from outputs");
  chk_upper_zero: assert property (O_AVS_READDATA[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_int_gate: assert property (!O_INT_N |-> O_IRQ || $past(O_IRQ))
    else $error("interrupt pin low without summary");
  chk_int_quiet: assert property (s_quiet |-> O_INT_N)
    else $error("interrupt pin low while summary clear");
  chk_reset_vals: assert property ($fell(I_RESET) |->
    O_INT_N && !O_IRQ && ctrl == 6'h00)
    else $error("outputs not at reset values");
endmodule : gsi_top_sva
`default_nettype wire

// ### tb/gsi_top_test.sv
// Self-checking test of the global status and interrupt logic.
`timescale 1ns/1ns
`default_nettype none
module gsi_top_test;
  localparam int SEC = 20;
  localparam logic [7:0] A_LAT = gsi_pkg::ADDR_STATUS_LATCHED;
  localparam logic [7:0] A_EN = gsi_pkg::ADDR_STATUS_IRQ_EN;
  localparam logic [7:0] A_SEN = gsi_pkg::ADDR_IRQ_SUMMARY_EN;
  localparam logic [7:0] A_LIVE = gsi_pkg::ADDR_LIVE_STATUS;
  localparam logic [7:0] A_PIN = gsi_pkg::ADDR_PIN_READBACK;
  localparam logic [7:0] A_CTL = gsi_pkg::ADDR_UPDATE_CONTROL;
  logic clk, rst, rd, wr, refclk, greq, sel, irq, int_n, wreq, r, e;
  logic [7:0] addr, gpio, g;
  logic [31:0] wdata, rdata, v;
  logic [3:0] locked, pdone, mode, m, d;
  int failures, n_checks, cyc, i, k;

  gsi_top #(.ONE_SEC_CYCLES(SEC)) u_dut (
    .I_REF_CLK(clk), .I_RESET(rst), .I_CLK_EN(1'b1),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .I_GPIO_PIN(gpio), .I_ADAPTER_REFCLK_PIN(refclk),
    .I_ADAPTER_PLL_LOCKED(locked), .I_PORT_UPDATE_DONE(pdone),
    .O_PORT_UPDATE_MODE(mode), .O_GLOBAL_UPDATE_REQUEST(greq),
    .O_REF8K_INPUT_SELECT(sel), .O_IRQ(irq), .O_INT_N(int_n));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus access; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= dat;
    // Values read right after an edge are the ones that edge sampled.
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk({31'h0, wreq}, 32'h0);
      end_sim();
    end
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(v & msk, exp);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  task automatic pulse_pin4;
    @(posedge clk);
    gpio[gsi_pkg::REF8K_PIN_INDEX] <= 1'b1;
    wait_cyc(5);
    gpio[gsi_pkg::REF8K_PIN_INDEX] <= 1'b0;
    wait_cyc(6);
  endtask : pulse_pin4

  function automatic logic exp_done(logic q, logic [3:0] md, logic [3:0] dn);
    return q & (&(dn | ~md));
  endfunction : exp_done

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    gpio = 8'h00;
    refclk = 1'b0;
    locked = 4'hf;
    pdone = 4'h0;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(32'h6102));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(A_EN, 32'hffff, 32'h0);
    rd_chk(A_SEN, 32'hffff, 32'h0);
    rd_chk(A_CTL, 32'hffff, 32'h0);
    rd_chk(A_LAT, 32'h1b, 32'h0);
    wr_reg(A_EN, 32'hffff);
    rd_chk(A_EN, 32'hffff, 32'h7);
    wr_reg(8'h44, 32'hffff);
    rd_chk(8'h44, 32'hffffffff, 32'h0);
    wr_reg(A_PIN, 32'hffff);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      g = (i == 0) ? 8'hff : 8'($urandom);
      @(posedge clk);
      gpio <= g;
      wait_cyc(6);
      rd_chk(A_PIN, 32'hffffffff, {24'h0, g});
    end
    gpio <= 8'h00;
    $display("test pin readback done");
    k = $urandom_range(3, 0);
    @(posedge clk);
    locked[k] <= 1'b0;
    wait_cyc(8);
    rd_chk(A_LIVE, 32'h2, 32'h2);
    wr_reg(A_LAT, 32'h0);
    rd_chk(A_LAT, 32'h2, 32'h2);
    wr_reg(A_LAT, 32'h2);
    wait_cyc(8);
    rd_chk(A_LAT, 32'h2, 32'h0);
    locked[k] <= 1'b1;
    wait_cyc(8);
    rd_chk(A_LIVE, 32'h2, 32'h0);
    $display("test lock lost done");
    wr_reg(A_LAT, 32'h1f);
    wait_cyc(SEC + 2);
    rd_chk(A_LAT, 32'h4, 32'h4);
    wr_reg(A_EN, 32'h4);
    wr_reg(A_SEN, 32'h1);
    wait_cyc(3);
    chk({30'h0, irq, int_n}, 32'h2);
    rd_chk(gsi_pkg::ADDR_IRQ_SUMMARY, 32'h1, 32'h1);
    wr_reg(A_SEN, 32'h0);
    wait_cyc(3);
    chk({30'h0, irq, int_n}, 32'h3);
    wr_reg(A_EN, 32'h0);
    wait_cyc(3);
    chk({30'h0, irq, int_n}, 32'h1);
    rd_chk(gsi_pkg::ADDR_IRQ_SUMMARY, 32'h1, 32'h0);
    $display("test interrupt done");
    for (i = 0; i < 10; i++) begin
      m = (i == 0) ? 4'h0 : 4'($urandom);
      d = (i == 1) ? 4'h0 : 4'($urandom);
      r = (i != 2);
      e = exp_done(r, m, d);
      wr_reg(A_CTL, 32'h0);
      wr_reg(A_LAT, 32'h1);
      pdone <= d;
      wr_reg(A_CTL, {27'h0, r, m});
      wait_cyc(2);
      rd_chk(A_LIVE, 32'h1, {31'h0, e});
      rd_chk(A_LAT, 32'h1, {31'h0, e});
      chk({27'h0, greq, mode}, {27'h0, r, m});
    end
    wr_reg(A_CTL, 32'h0);
    $display("test update done");
    wr_reg(A_LAT, 32'h18);
    refclk <= 1'b1;
    wait_cyc(5);
    refclk <= 1'b0;
    pulse_pin4();
    rd_chk(A_LAT, 32'h18, 32'h08);
    wr_reg(A_CTL, 32'h20);
    wait_cyc(1);
    chk({31'h0, sel}, 32'h1);
    pulse_pin4();
    rd_chk(A_LAT, 32'h10, 32'h10);
    $display("test activity done");
    end_sim();
  end
endmodule : gsi_top_test

bind gsi_top gsi_top_sva u_sva (
  .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_PORT_UPDATE_MODE(O_PORT_UPDATE_MODE),
  .O_GLOBAL_UPDATE_REQUEST(O_GLOBAL_UPDATE_REQUEST),
  .O_REF8K_INPUT_SELECT(O_REF8K_INPUT_SELECT), .O_IRQ(O_IRQ),
  .O_INT_N(O_INT_N));
`default_nettype wire

// ### verilog/gsi_pkg.sv
// Constants, register map and field layout of the global status logic.
package gsi_pkg;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ONE_SECOND_NS = 1000000000;
  localparam int unsigned ONE_SEC_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_CNT_WIDTH = 26;

  // Sizes.
  localparam int unsigned PORT_COUNT = 4;
  localparam int unsigned PLL_COUNT = 4;
  localparam int unsigned GPIO_COUNT = 8;
  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_SUMMARY = 8'h10;
  localparam logic [7:0] IDX_IRQ_SUMMARY_EN = 8'h12;
  localparam logic [7:0] IDX_LIVE_STATUS = 8'h14;
  localparam logic [7:0] IDX_STATUS_LATCHED = 8'h16;
  localparam logic [7:0] IDX_STATUS_IRQ_EN = 8'h18;
  localparam logic [7:0] IDX_PIN_READBACK = 8'h1c;
  localparam logic [7:0] IDX_UPDATE_CONTROL = 8'h1e;

  localparam logic [7:0] ADDR_IRQ_SUMMARY = {IDX_IRQ_SUMMARY[5:0], 2'b00};
  localparam logic [7:0] ADDR_IRQ_SUMMARY_EN =
    {IDX_IRQ_SUMMARY_EN[5:0], 2'b00};
  localparam logic [7:0] ADDR_LIVE_STATUS = {IDX_LIVE_STATUS[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS_LATCHED =
    {IDX_STATUS_LATCHED[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS_IRQ_EN =
    {IDX_STATUS_IRQ_EN[5:0], 2'b00};
  localparam logic [7:0] ADDR_PIN_READBACK = {IDX_PIN_READBACK[5:0], 2'b00};
  localparam logic [7:0] ADDR_UPDATE_CONTROL =
    {IDX_UPDATE_CONTROL[5:0], 2'b00};

  // Status field positions, shared by live, latched and enable registers.
  localparam int unsigned BIT_UPDATE_DONE = 0;
  localparam int unsigned BIT_LOCK_LOST = 1;
  localparam int unsigned BIT_ONE_SECOND = 2;
  localparam int unsigned BIT_REFCLK_ACT = 3;
  localparam int unsigned BIT_REF8K_ACT = 4;
  localparam int unsigned BIT_SUMMARY = 0;
  localparam logic [15:0] LATCHED_MASK = 16'h001f;
  localparam logic [15:0] IRQ_EN_MASK = 16'h0007;

  // Update control register layout.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_REQUEST_BIT = 4;
  localparam int unsigned CTRL_REF8K_SEL_BIT = 5;
  localparam logic [15:0] CTRL_MASK = 16'h003f;

  // General-purpose pin 4 sits at index 3.
  localparam int unsigned REF8K_PIN_INDEX = 3;

  // Reset values.
  localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
  localparam logic [15:0] LATCHED_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic SUMMARY_EN_RESET = 1'b0;
  localparam logic [PLL_COUNT-1:0] LOCK_SYNC_RESET = 4'h0;

  // Bus answer sequencing.
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } gsi_bus_e;

endpackage : gsi_pkg

// ### verilog/gsi_sync.sv
// Three-stage input synchroniser that accepts a change once stages agree.
`timescale 1ns/1ns
`default_nettype none
module gsi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Data.
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] mid_reg;
  logic [WIDTH-1:0] mid_next;
  logic [WIDTH-1:0] late_reg;
  logic [WIDTH-1:0] late_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;
  logic [WIDTH-1:0] agree;

  always_comb begin
    meta_next = i_d;
    mid_next = meta_reg;
    late_next = mid_reg;
    agree = mid_reg ~^ late_reg;
    q_next = (q_reg & ~agree) | (late_reg & agree);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= RESET_VALUE;
      mid_reg <= RESET_VALUE;
      late_reg <= RESET_VALUE;
      q_reg <= RESET_VALUE;
    end else if (i_clk_en) begin
      meta_reg <= meta_next;
      mid_reg <= mid_next;
      late_reg <= late_next;
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule : gsi_sync
`default_nettype wire

// ### verilog/gsi_top.sv
// Global status, latched status and interrupt logic with pin read-back.
//
// Notes on behaviour
// - Live lock-lost is high while any adapter PLL reports unlocked.
// - Live update-done is the AND of done bits of globally updated ports.
// - Update-done reads 0 while the request is low or work is pending.
// - Pin 4 activity sets its latched bit only while selected as 8 kHz in.
// - Adapter reference clock pin activity sets its latched bit.
// - A one-second tick sets the one-second latched bit every second.
// - Latched lock-lost sets only on a rising edge of live lock-lost.
// - Latched update-done sets only on a rising edge of live update-done.
// - The summary flag is set by any enabled one of the low three bits.
// - The interrupt pin goes low only when both enable levels are on.
// - The read-back register shows the present level of all eight pins.
// - The interrupt pin is low while summary and its enable are set.
// - Only ports in global update mode take part in the update AND.
`timescale 1ns/1ns
`default_nettype none
module gsi_top #(
  parameter int unsigned ONE_SEC_CYCLES = gsi_pkg::ONE_SEC_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CLK_EN,
  // Avalon-MM slave.
  input wire logic [gsi_pkg::ADDR_WIDTH-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [gsi_pkg::DATA_WIDTH-1:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [gsi_pkg::DATA_WIDTH-1:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Device pins and PLL lock indications.
  input wire logic [gsi_pkg::GPIO_COUNT-1:0] I_GPIO_PIN,
  input wire logic I_ADAPTER_REFCLK_PIN,
  input wire logic [gsi_pkg::PLL_COUNT-1:0] I_ADAPTER_PLL_LOCKED,
  // Per-port update status from the port logic.
  input wire logic [gsi_pkg::PORT_COUNT-1:0] I_PORT_UPDATE_DONE,
  // Control outputs to the rest of the device.
  output logic [gsi_pkg::PORT_COUNT-1:0] O_PORT_UPDATE_MODE,
  output logic O_GLOBAL_UPDATE_REQUEST,
  output logic O_REF8K_INPUT_SELECT,
  // Interrupts.
  output logic O_IRQ,
  output logic O_INT_N
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  logic [gsi_pkg::GPIO_COUNT-1:0] gpio_sync;
  logic [0:0] refclk_sync;
  logic [gsi_pkg::PLL_COUNT-1:0] lock_sync;

  gsi_sync #(
    .WIDTH(gsi_pkg::GPIO_COUNT),
    .RESET_VALUE(8'h00)
  ) u_gpio_sync (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_clk_en(I_CLK_EN),
    .i_d(I_GPIO_PIN),
    .o_q(gpio_sync)
  );

  gsi_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_refclk_sync (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_clk_en(I_CLK_EN),
    .i_d(I_ADAPTER_REFCLK_PIN),
    .o_q(refclk_sync)
  );

  gsi_sync #(
    .WIDTH(gsi_pkg::PLL_COUNT),
    .RESET_VALUE(gsi_pkg::LOCK_SYNC_RESET)
  ) u_lock_sync (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_clk_en(I_CLK_EN),
    .i_d(I_ADAPTER_PLL_LOCKED),
    .o_q(lock_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // Software registers and bus slave state.

  gsi_pkg::gsi_bus_e bus_state_reg;
  gsi_pkg::gsi_bus_e bus_state_next;
  logic [gsi_pkg::DATA_WIDTH-1:0] readdata_reg;
  logic [gsi_pkg::DATA_WIDTH-1:0] readdata_next;
  logic [15:0] irq_en_reg;
  logic [15:0] irq_en_next;
  logic summary_en_reg;
  logic summary_en_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] latched_reg;
  logic [15:0] latched_next;

  //////////////////////////////////////////////////////////////////////////
  // Live status.

  logic [gsi_pkg::PORT_COUNT-1:0] port_mode;
  logic update_request;
  logic ref8k_select;
  logic lock_lost;
  logic update_done;
  logic [15:0] live_status;

  assign port_mode = ctrl_reg[gsi_pkg::CTRL_MODE_LSB +: gsi_pkg::PORT_COUNT];
  assign update_request = ctrl_reg[gsi_pkg::CTRL_REQUEST_BIT];
  assign ref8k_select = ctrl_reg[gsi_pkg::CTRL_REF8K_SEL_BIT];

  // Ports in per-port mode are forced to one so they do not hold the AND.
  assign lock_lost = ~(&lock_sync);
  assign update_done = update_request &
    (&(I_PORT_UPDATE_DONE | ~port_mode));

  always_comb begin
    live_status = 16'h0000;
    live_status[gsi_pkg::BIT_UPDATE_DONE] = update_done;
    live_status[gsi_pkg::BIT_LOCK_LOST] = lock_lost;
  end

  //////////////////////////////////////////////////////////////////////////
  // Event detection.

  logic lock_lost_prev_reg;
  logic lock_lost_prev_next;
  logic update_done_prev_reg;
  logic update_done_prev_next;
  logic refclk_prev_reg;
  logic refclk_prev_next;
  logic ref8k_prev_reg;
  logic ref8k_prev_next;
  logic [gsi_pkg::SEC_CNT_WIDTH-1:0] sec_cnt_reg;
  logic [gsi_pkg::SEC_CNT_WIDTH-1:0] sec_cnt_next;
  logic sec_tick;
  logic [15:0] set_events;
  localparam logic [gsi_pkg::SEC_CNT_WIDTH-1:0] SEC_LAST =
    gsi_pkg::SEC_CNT_WIDTH'(ONE_SEC_CYCLES - 1);

  always_comb begin
    lock_lost_prev_next = lock_lost;
    update_done_prev_next = update_done;
    refclk_prev_next = refclk_sync[0];
    ref8k_prev_next = gpio_sync[gsi_pkg::REF8K_PIN_INDEX];
    sec_tick = (sec_cnt_reg == SEC_LAST);
    if (sec_tick) begin
      sec_cnt_next = '0;
    end else begin
      sec_cnt_next = sec_cnt_reg + 1'b1;
    end
    set_events = 16'h0000;
    set_events[gsi_pkg::BIT_UPDATE_DONE] =
      update_done & ~update_done_prev_reg;
    set_events[gsi_pkg::BIT_LOCK_LOST] =
      lock_lost & ~lock_lost_prev_reg;
    set_events[gsi_pkg::BIT_ONE_SECOND] = sec_tick;
    set_events[gsi_pkg::BIT_REFCLK_ACT] =
      refclk_sync[0] & ~refclk_prev_reg;
    set_events[gsi_pkg::BIT_REF8K_ACT] = ref8k_select &
      gpio_sync[gsi_pkg::REF8K_PIN_INDEX] & ~ref8k_prev_reg;
  end

  // Previous values start at the reset view of their sources so that
  // leaving reset never counts as an edge.
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      lock_lost_prev_reg <= 1'b1;
      update_done_prev_reg <= 1'b0;
      refclk_prev_reg <= 1'b0;
      ref8k_prev_reg <= 1'b0;
      sec_cnt_reg <= '0;
    end else if (I_CLK_EN) begin
      lock_lost_prev_reg <= lock_lost_prev_next;
      update_done_prev_reg <= update_done_prev_next;
      refclk_prev_reg <= refclk_prev_next;
      ref8k_prev_reg <= ref8k_prev_next;
      sec_cnt_reg <= sec_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access takes effect.

  logic bus_req;
  logic bus_take;
  logic write_take;
  logic [7:0] word_addr;
  logic [15:0] wdata;
  logic lane0;
  logic lane1;
  logic [15:0] lane_mask;
  logic [15:0] read_mux;
  logic summary_flag;

  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign bus_take = bus_req & (bus_state_reg == gsi_pkg::BUS_ANSWER);
  assign write_take = bus_take & I_AVS_WRITE;
  assign word_addr = {I_AVS_ADDRESS[7:2], 2'b00};
  assign wdata = I_AVS_WRITEDATA[15:0];
  assign lane0 = I_AVS_BYTEENABLE[0];
  assign lane1 = I_AVS_BYTEENABLE[1];
  assign lane_mask = {{8{lane1}}, {8{lane0}}};
  assign O_AVS_WAITREQUEST = bus_req & (bus_state_reg == gsi_pkg::BUS_IDLE);

  always_comb begin
    case (word_addr)
      gsi_pkg::ADDR_IRQ_SUMMARY: read_mux = {15'h0000, summary_flag};
      gsi_pkg::ADDR_IRQ_SUMMARY_EN: read_mux = {15'h0000, summary_en_reg};
      gsi_pkg::ADDR_LIVE_STATUS: read_mux = live_status;
      gsi_pkg::ADDR_STATUS_LATCHED: read_mux = latched_reg;
      gsi_pkg::ADDR_STATUS_IRQ_EN: read_mux = irq_en_reg;
      gsi_pkg::ADDR_PIN_READBACK: read_mux = {8'h00, gpio_sync};
      gsi_pkg::ADDR_UPDATE_CONTROL: read_mux = ctrl_reg;
      default: read_mux = 16'h0000;
    endcase
  end

  always_comb begin
    bus_state_next = gsi_pkg::BUS_IDLE;
    readdata_next = readdata_reg;
    case (bus_state_reg)
      gsi_pkg::BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = gsi_pkg::BUS_ANSWER;
        end
        if (I_AVS_READ) begin
          readdata_next = {16'h0000, read_mux};
        end
      end
      gsi_pkg::BUS_ANSWER: begin
        bus_state_next = gsi_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_next = gsi_pkg::BUS_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Register updates.

  logic [15:0] w1c_clear;

  always_comb begin
    irq_en_next = irq_en_reg;
    summary_en_next = summary_en_reg;
    ctrl_next = ctrl_reg;
    w1c_clear = 16'h0000;
    if (write_take) begin
      case (word_addr)
        gsi_pkg::ADDR_IRQ_SUMMARY_EN: begin
          if (lane0) begin
            summary_en_next = wdata[gsi_pkg::BIT_SUMMARY];
          end
        end
        gsi_pkg::ADDR_STATUS_IRQ_EN: begin
          irq_en_next = ((irq_en_reg & ~lane_mask) | (wdata & lane_mask)) &
            gsi_pkg::IRQ_EN_MASK;
        end
        gsi_pkg::ADDR_STATUS_LATCHED: begin
          w1c_clear = wdata & lane_mask & gsi_pkg::LATCHED_MASK;
        end
        gsi_pkg::ADDR_UPDATE_CONTROL: begin
          ctrl_next = ((ctrl_reg & ~lane_mask) | (wdata & lane_mask)) &
            gsi_pkg::CTRL_MASK;
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
    // A new event in the clearing cycle keeps the bit set.
    latched_next = ((latched_reg & ~w1c_clear) | set_events) &
      gsi_pkg::LATCHED_MASK;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      bus_state_reg <= gsi_pkg::BUS_IDLE;
      readdata_reg <= '0;
      irq_en_reg <= gsi_pkg::IRQ_EN_RESET;
      summary_en_reg <= gsi_pkg::SUMMARY_EN_RESET;
      ctrl_reg <= gsi_pkg::CTRL_RESET;
      latched_reg <= gsi_pkg::LATCHED_RESET;
    end else if (I_CLK_EN) begin
      bus_state_reg <= bus_state_next;
      readdata_reg <= readdata_next;
      irq_en_reg <= irq_en_next;
      summary_en_reg <= summary_en_next;
      ctrl_reg <= ctrl_next;
      latched_reg <= latched_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt generation.

  logic irq_reg;
  logic irq_next;
  logic int_n_reg;
  logic int_n_next;

  assign summary_flag = |(latched_reg & irq_en_reg &
    gsi_pkg::IRQ_EN_MASK);

  always_comb begin
    irq_next = summary_flag;
    int_n_next = ~(summary_flag & summary_en_reg);
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      irq_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end else if (I_CLK_EN) begin
      irq_reg <= irq_next;
      int_n_reg <= int_n_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign O_AVS_READDATA = readdata_reg;
  assign O_PORT_UPDATE_MODE = port_mode;
  assign O_GLOBAL_UPDATE_REQUEST = update_request;
  assign O_REF8K_INPUT_SELECT = ref8k_select;
  assign O_IRQ = irq_reg;
  assign O_INT_N = int_n_reg;

endmodule : gsi_top
`default_nettype wire
